// ==== fcp_pkg.sv ====
package fcp_pkg;
   // Register offsets
   localparam logic [3:0] FCP_SEC_OFFSET = 4'h1;
   localparam logic [3:0] FCP_CFG_OFFSET = 4'h3;
   localparam logic [3:0] FCP_PROT_OFFSET = 4'h4;
   localparam logic [3:0] FCP_STAT_OFFSET = 4'h5;
   localparam logic [3:0] FCP_CMD_OFFSET = 4'h6;
   // Configuration register fields
   localparam int FCP_CFG_BEIE_BIT = 7;
   localparam int FCP_CFG_CMD_DONE_IRQ_ENABLE_BIT = 6;
   localparam int FCP_CFG_KEYG_BIT = 5;
   localparam logic [7:0] FCP_CFG_RESET = 8'h00;
   // Protection register fields
   localparam int FCP_PROT_POL_BIT = 7;
   localparam int FCP_PROT_SPARE_BIT = 6;
   localparam int FCP_PROT_HDIS_BIT = 5;
   localparam int FCP_PROT_HS_LSB = 3;
   localparam int FCP_PROT_LDIS_BIT = 2;
   localparam int FCP_PROT_LS_LSB = 0;
   localparam logic [7:0] FCP_PROT_RESET = 8'hFF;
   // Nonvolatile byte holding the protection setting
   localparam logic [15:0] FCP_PROT_NV_ADDR = 16'hFF0D;
   // Security field
   localparam int FCP_SEC_KEY_LSB = 6;
   localparam logic [1:0] FCP_KEY_ENABLED = 2'h2;
   // Status register fields
   localparam int FCP_STAT_BEF_BIT = 7;
   localparam int FCP_STAT_CCF_BIT = 6;
   localparam int FCP_STAT_PV_BIT = 5;
   // Command code register (write only in effect)
   localparam logic [7:0] FCP_CMD_PROGRAM = 8'h20;
   localparam logic [7:0] FCP_CMD_SECT_ERASE = 8'h40;
   localparam logic [7:0] FCP_CMD_MASS_ERASE = 8'h41;
   // Range bounds
   localparam logic [15:0] FCP_HIGH_END = 16'hFFFF;
   localparam logic [15:0] FCP_HIGH_START0 = 16'hF800;
   localparam logic [15:0] FCP_HIGH_START1 = 16'hF000;
   localparam logic [15:0] FCP_HIGH_START2 = 16'hE000;
   localparam logic [15:0] FCP_HIGH_START3 = 16'hC000;
   localparam logic [15:0] FCP_LOW_START = 16'h4000;
   localparam logic [15:0] FCP_LOW_END0 = 16'h43FF;
   localparam logic [15:0] FCP_LOW_END1 = 16'h47FF;
   localparam logic [15:0] FCP_LOW_END2 = 16'h4FFF;
   localparam logic [15:0] FCP_LOW_END3 = 16'h5FFF;
   // Boot load sequencing
   typedef enum logic [1:0] {FCP_BOOT_REQ, FCP_BOOT_WAIT, FCP_BOOT_DONE} fcp_boot_t;
endpackage : fcp_pkg

// ==== fcp_range_check.sv ====
`timescale 1ns/1ps
// Decides whether an address lies in protected space for a protection setting
module fcp_range_check
   import fcp_pkg::*;
(
   input wire logic [7:0] protSetting,
   input wire logic [15:0] addr,
   output logic isProtected,
   output logic allOpen
);
   logic [15:0] highStart;
   logic [15:0] lowEnd;
   logic inHigh;
   logic inLow;
   logic highActive;
   logic lowActive;

   // Range bounds selected by the size fields
   always_comb begin
      unique case (protSetting[FCP_PROT_HS_LSB +: 2]) // RQ18
         2'h0: highStart = FCP_HIGH_START0;
         2'h1: highStart = FCP_HIGH_START1;
         2'h2: highStart = FCP_HIGH_START2;
         2'h3: highStart = FCP_HIGH_START3;
      endcase
      unique case (protSetting[FCP_PROT_LS_LSB +: 2]) // RQ19
         2'h0: lowEnd = FCP_LOW_END0;
         2'h1: lowEnd = FCP_LOW_END1;
         2'h2: lowEnd = FCP_LOW_END2;
         2'h3: lowEnd = FCP_LOW_END3;
      endcase
   end

   // Membership and polarity
   assign inHigh = (addr >= highStart) && (addr <= FCP_HIGH_END);
   assign inLow = (addr >= FCP_LOW_START) && (addr <= lowEnd);
   assign highActive = !protSetting[FCP_PROT_HDIS_BIT] && inHigh; // RQ15
   assign lowActive = !protSetting[FCP_PROT_LDIS_BIT] && inLow; // RQ16
   assign isProtected = protSetting[FCP_PROT_POL_BIT] ? (highActive || lowActive)
                        : !(highActive || lowActive); // RQ14
   assign allOpen = protSetting[FCP_PROT_POL_BIT] && protSetting[FCP_PROT_HDIS_BIT]
                    && protSetting[FCP_PROT_LDIS_BIT]; // RQ13
endmodule : fcp_range_check

// ==== fcp_flash_protect.sv ====
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
// Summary of operation
// RQ1 - Config register keeps only two interrupt enables and key gate; others read zero.
// RQ2 - Key gate accepts writes only while backdoor enable field is enabled.
// RQ3 - Buffer-empty interrupt requested while its enable and flag are both set.
// RQ4 - Command-done interrupt requested while its enable and flag are both set.
// RQ5 - Gate clear: array writes start commands; set: key words, reads invalid.
// RQ6 - Protection register at offset 0x4 is readable in every mode.
// RQ7 - Polarity bit can only be cleared by software, never set.
// RQ8 - Low size field writable only while low range disable bit is set.
// RQ9 - High size field writable only while high range disable bit is set.
// RQ10 - Protection register loads from nonvolatile byte 0xFF0D during reset; here it holds FCP_PROT_RESET and loads the byte after reset ends.
// RQ11 - To change boot protection, unprotect top sector then program 0xFF0D.
// RQ12 - Program or erase into protected space is refused and flags violation.
// RQ13 - Mass erase only with all protection off; otherwise flags violation.
// RQ14 - Polarity selects whether enabled ranges are protected or unprotected.
// RQ15 - High disable bit zero activates the top-of-map range.
// RQ16 - Low disable bit zero activates the low sector range.
// RQ17 - Spare nonvolatile bit 6 should stay erased for future use.
// RQ18 - High size selects 2K, 4K, 8K or 16K ending at 0xFFFF.
// RQ19 - Low size selects 1K, 2K, 4K or 8K starting at 0x4000.
// RQ20 - Writes that would remove protection are ignored entirely.
// RQ21 - Backdoor access enabled only when key enable field equals 10.
// RQ22 - Interrupt outputs are enable AND flag, dropping when either clears.
module fcp_flash_protect
   import fcp_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic [7:0] securityState,
   input wire logic bufferEmptySet,
   input wire logic cmdDoneFlag,
   input wire logic arrayWr,
   input wire logic arrayRd,
   input wire logic [15:0] arrayAddr,
   output logic [15:0] nvReadAddr,
   output logic nvReadReq,
   input wire logic nvReadValid,
   input wire logic [7:0] nvReadData,
   output logic cmdStart,
   output logic [7:0] cmdCode,
   output logic [15:0] cmdAddr,
   output logic keyWordWr,
   output logic arrayReadInvalid,
   output logic bufferEmptyIrq,
   output logic cmdDoneIrq
);
   logic [7:0] cfg_q;
   logic [7:0] prot_q;
   logic [7:0] prot_d;
   logic bufEmpty_q;
   logic violation_q;
   logic [7:0] pendCmd_q;
   logic cmdPend_q;
   logic [15:0] cmdAddr_q;
   fcp_boot_t boot_q;
   logic keyEnabled;
   logic wrCfg;
   logic wrProt;
   logic wrStat;
   logic wrCmd;
   logic targetProt;
   logic allOpen;
   logic isMass;
   logic refuse;
   logic cmdGo;
   logic [2:0] curScen;
   logic [2:0] newScen;
   logic scenOk;
   logic [7:0] statView;

   // Write decode
   assign wrCfg = regWr && (regAddr == FCP_CFG_OFFSET);
   assign wrProt = regWr && (regAddr == FCP_PROT_OFFSET);
   assign wrStat = regWr && (regAddr == FCP_STAT_OFFSET);
   assign wrCmd = regWr && (regAddr == FCP_CMD_OFFSET);
   assign keyEnabled = (securityState[FCP_SEC_KEY_LSB +: 2] == FCP_KEY_ENABLED); // RQ21

   // Configuration register
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_q <= FCP_CFG_RESET;
      end else if (wrCfg) begin
         cfg_q[FCP_CFG_BEIE_BIT] <= regWdata[FCP_CFG_BEIE_BIT]; // RQ1
         cfg_q[FCP_CFG_CMD_DONE_IRQ_ENABLE_BIT] <= regWdata[FCP_CFG_CMD_DONE_IRQ_ENABLE_BIT]; // RQ1
         if (keyEnabled) begin
            cfg_q[FCP_CFG_KEYG_BIT] <= regWdata[FCP_CFG_KEYG_BIT]; // RQ2
         end
      end
   end

   // Scenario code: polarity, high disable, low disable
   function automatic logic [2:0] scenario(input logic [7:0] p);
      scenario = {p[FCP_PROT_POL_BIT], p[FCP_PROT_HDIS_BIT], p[FCP_PROT_LDIS_BIT]};
   endfunction : scenario

   // Candidate protection value after field lock rules
   always_comb begin
      prot_d = prot_q;
      prot_d[FCP_PROT_POL_BIT] = prot_q[FCP_PROT_POL_BIT] & regWdata[FCP_PROT_POL_BIT]; // RQ7
      prot_d[FCP_PROT_HDIS_BIT] = regWdata[FCP_PROT_HDIS_BIT];
      prot_d[FCP_PROT_LDIS_BIT] = regWdata[FCP_PROT_LDIS_BIT];
      if (prot_q[FCP_PROT_HDIS_BIT]) begin
         prot_d[FCP_PROT_HS_LSB +: 2] = regWdata[FCP_PROT_HS_LSB +: 2]; // RQ9
      end
      if (prot_q[FCP_PROT_LDIS_BIT]) begin
         prot_d[FCP_PROT_LS_LSB +: 2] = regWdata[FCP_PROT_LS_LSB +: 2]; // RQ8
      end
   end

   // Allowed transitions: only adding protection
   assign curScen = scenario(prot_q);
   assign newScen = scenario(prot_d);
   always_comb begin
      if (curScen[2] && newScen[2]) begin
         // Open polarity: disable bits may only clear
         scenOk = ((newScen & ~curScen) == 3'h0); // RQ20
      end else if (!curScen[2] && !newScen[2]) begin
         // Closed polarity: disable bits may only set
         scenOk = ((curScen & ~newScen) == 3'h0); // RQ20
      end else if (curScen[2] && !newScen[2]) begin
         // Open to closed: full protection, or from all open any closed with a disable set
         scenOk = (newScen == 3'h3) || (curScen == 3'h7 && newScen[1:0] != 2'h0); // RQ20
      end else begin
         scenOk = 1'b0;
      end
   end

   // Protection register, loaded from the nonvolatile byte after reset
   always_ff @(posedge clk) begin
      if (srst) begin
         prot_q <= FCP_PROT_RESET;
         boot_q <= FCP_BOOT_REQ;
      end else begin
         unique case (boot_q)
            FCP_BOOT_REQ: boot_q <= FCP_BOOT_WAIT;
            FCP_BOOT_WAIT: begin
               if (nvReadValid) begin
                  prot_q <= nvReadData; // RQ10
                  boot_q <= FCP_BOOT_DONE;
               end
            end
            FCP_BOOT_DONE: begin
               if (wrProt && scenOk) begin
                  prot_q <= prot_d; // RQ20
               end
            end
         endcase
      end
   end

   // Boot read request
   always_ff @(posedge clk) begin
      if (srst) begin
         nvReadReq <= 1'b0;
         nvReadAddr <= FCP_PROT_NV_ADDR;
      end else begin
         nvReadReq <= (boot_q == FCP_BOOT_REQ); // RQ10
         nvReadAddr <= FCP_PROT_NV_ADDR;
      end
   end

   // Protection lookup for the latched command address
   fcp_range_check uRange (
      .protSetting(prot_q),
      .addr(cmdAddr_q),
      .isProtected(targetProt),
      .allOpen(allOpen)
   );

   assign isMass = (pendCmd_q == FCP_CMD_MASS_ERASE);
   assign refuse = isMass ? !allOpen : targetProt; // RQ12 RQ13
   assign cmdGo = cmdPend_q && (boot_q == FCP_BOOT_DONE);

   // Latch array address and command code
   always_ff @(posedge clk) begin
      if (srst) begin
         cmdAddr_q <= 16'h0000;
         pendCmd_q <= 8'h00;
         cmdPend_q <= 1'b0;
      end else begin
         if (arrayWr && !cfg_q[FCP_CFG_KEYG_BIT]) begin
            cmdAddr_q <= arrayAddr; // RQ5
         end
         if (wrCmd) begin
            pendCmd_q <= regWdata;
         end
         cmdPend_q <= wrCmd;
      end
   end

   // Status flags: violation and buffer empty; set wins over clear
   always_ff @(posedge clk) begin
      if (srst) begin
         violation_q <= 1'b0;
         bufEmpty_q <= 1'b1;
      end else begin
         if (cmdGo && refuse) begin
            violation_q <= 1'b1; // RQ12 RQ13
         end else if (wrStat && regWdata[FCP_STAT_PV_BIT]) begin
            violation_q <= 1'b0;
         end
         if (bufferEmptySet) begin
            bufEmpty_q <= 1'b1;
         end else if (wrStat && regWdata[FCP_STAT_BEF_BIT]) begin
            bufEmpty_q <= 1'b0;
         end
      end
   end

   // Command launch toward the command controller
   always_ff @(posedge clk) begin
      if (srst) begin
         cmdStart <= 1'b0;
         cmdCode <= 8'h00;
         cmdAddr <= 16'h0000;
      end else begin
         cmdStart <= cmdGo && !refuse && !violation_q; // RQ12
         cmdCode <= pendCmd_q;
         cmdAddr <= cmdAddr_q;
      end
   end

   // Key word path and invalid read marker
   always_ff @(posedge clk) begin
      if (srst) begin
         keyWordWr <= 1'b0;
         arrayReadInvalid <= 1'b0;
      end else begin
         keyWordWr <= arrayWr && cfg_q[FCP_CFG_KEYG_BIT]; // RQ5
         arrayReadInvalid <= arrayRd && cfg_q[FCP_CFG_KEYG_BIT]; // RQ5
      end
   end

   // Interrupt request levels
   always_ff @(posedge clk) begin
      if (srst) begin
         bufferEmptyIrq <= 1'b0;
         cmdDoneIrq <= 1'b0;
      end else begin
         bufferEmptyIrq <= cfg_q[FCP_CFG_BEIE_BIT] && bufEmpty_q; // RQ3 RQ22
         cmdDoneIrq <= cfg_q[FCP_CFG_CMD_DONE_IRQ_ENABLE_BIT] && cmdDoneFlag; // RQ4 RQ22
      end
   end

   // Status view
   always_comb begin
      statView = 8'h00;
      statView[FCP_STAT_BEF_BIT] = bufEmpty_q;
      statView[FCP_STAT_CCF_BIT] = cmdDoneFlag;
      statView[FCP_STAT_PV_BIT] = violation_q;
   end

   // Read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge clk) begin
      if (srst) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         unique case (regAddr)
            FCP_SEC_OFFSET: regRdata <= securityState;
            FCP_CFG_OFFSET: regRdata <= cfg_q; // RQ1
            FCP_PROT_OFFSET: regRdata <= prot_q; // RQ6
            FCP_STAT_OFFSET: regRdata <= statView;
            default: regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end
endmodule : fcp_flash_protect

// ==== fcp_flash_protect_assertions.sv ====
`timescale 1ns/1ps
// Port-level checks for the flash protection block
module fcp_flash_protect_checker
   import fcp_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   input wire logic cmdDoneFlag,
   input wire logic arrayWr,
   input wire logic arrayRd,
   input wire logic [15:0] nvReadAddr,
   input wire logic nvReadReq,
   input wire logic cmdStart,
   input wire logic keyWordWr,
   input wire logic arrayReadInvalid,
   input wire logic bufferEmptyIrq,
   input wire logic cmdDoneIrq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Read data only in the answer cycle; config spare bits read zero
   a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
      else $error("read data outside answer cycle");
   a_cfg_zero: assert property ($past(regRd) && $past(regAddr) == FCP_CFG_OFFSET
      |-> regRdata[4:0] == 5'h00)
      else $error("config spare bits not zero");
   // Boot fetch of the protection byte
   a_nv_addr: assert property (nvReadAddr == FCP_PROT_NV_ADDR)
      else $error("boot fetch address wrong");
   a_nv_pulse: assert property (nvReadReq |=> !nvReadReq)
      else $error("boot fetch request too long");
   // Key gate effects, command start and done interrupt follow their causes
   a_key_word: assert property (keyWordWr |-> $past(arrayWr))
      else $error("key word without array write");
   a_rd_invalid: assert property (arrayReadInvalid |-> $past(arrayRd))
      else $error("read invalid without array read");
   a_cmd_cause: assert property (cmdStart |-> $past(regWr, 2)
      && $past(regAddr, 2) == FCP_CMD_OFFSET)
      else $error("command start without command write");
   a_done_irq: assert property (!$past(cmdDoneFlag) |-> !cmdDoneIrq)
      else $error("done interrupt without flag");
   c_cmd: cover property (cmdStart);
   c_key: cover property (keyWordWr);
   c_irq: cover property (bufferEmptyIrq && cmdDoneIrq);
endmodule : fcp_flash_protect_checker

// ==== fcp_nv_model.sv ====
`timescale 1ns/1ps
// Nonvolatile array answering the boot fetch after a short delay
module fcp_nv_model
   import fcp_pkg::*;
#(
   parameter logic [7:0] BOOT_BYTE = 8'hFD,
   parameter int DELAY = 3
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [15:0] nvReadAddr,
   input wire logic nvReadReq,
   output logic nvReadValid,
   output logic [7:0] nvReadData
);
   int cnt;
   // Count down from the request, then one valid pulse
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt <= 0;
         nvReadValid <= 1'b0;
      end else begin
         nvReadValid <= 1'b0;
         if (nvReadReq && nvReadAddr == FCP_PROT_NV_ADDR) begin
            cnt <= DELAY;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
            nvReadValid <= (cnt == 1);
         end
      end
   end
   // Data is junk outside the valid cycle
   assign nvReadData = nvReadValid ? BOOT_BYTE : ~BOOT_BYTE;
endmodule : fcp_nv_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top
   import fcp_pkg::*;
;
   logic clk = 0, srst = 1, regWr = 0, regRd = 0, bufferEmptySet = 0, cmdDoneFlag = 0;
   logic arrayWr = 0, arrayRd = 0, nvReadReq, nvReadValid, cmdStart, keyWordWr;
   logic arrayReadInvalid, bufferEmptyIrq, cmdDoneIrq;
   logic [3:0] regAddr = 0;
   logic [7:0] regWdata = 0, securityState = 0, regRdata, nvReadData, cmdCode, rv;
   logic [15:0] arrayAddr = 0, nvReadAddr, cmdAddr;
   int bad_count = 0, checks_done = 0;
   // Security, offset, write data, expected read back
   localparam logic [27:0] ROWS [0:12] = '{28'h00_3_FF_C0, 28'h40_3_FF_C0, 28'hC0_3_FF_C0,
      28'h80_3_FF_E0, 28'h80_3_00_00, 28'h00_F_FF_00, 28'h00_4_FD_FD, 28'h00_4_F9_F9,
      28'h00_4_FA_F9, 28'h00_4_FD_F9, 28'h00_4_79_F9, 28'h00_4_D9_D9, 28'h00_4_C9_D9};
   // Code, address, start expected
   localparam logic [24:0] CMDS [0:4] = '{{FCP_CMD_PROGRAM, 16'h47FF, 1'b0},
      {FCP_CMD_PROGRAM, 16'h4800, 1'b1}, {FCP_CMD_PROGRAM, 16'hBFFF, 1'b1},
      {FCP_CMD_SECT_ERASE, 16'hC000, 1'b0}, {FCP_CMD_MASS_ERASE, 16'h0000, 1'b0}};
   fcp_flash_protect u_fcp_flash_protect (.clk(clk), .srst(srst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .securityState(securityState), .bufferEmptySet(bufferEmptySet),
      .cmdDoneFlag(cmdDoneFlag), .arrayWr(arrayWr), .arrayRd(arrayRd),
      .arrayAddr(arrayAddr), .nvReadAddr(nvReadAddr), .nvReadReq(nvReadReq),
      .nvReadValid(nvReadValid), .nvReadData(nvReadData), .cmdStart(cmdStart),
      .cmdCode(cmdCode), .cmdAddr(cmdAddr), .keyWordWr(keyWordWr),
      .arrayReadInvalid(arrayReadInvalid), .bufferEmptyIrq(bufferEmptyIrq),
      .cmdDoneIrq(cmdDoneIrq));
   fcp_nv_model u_fcp_nv_model (.clk(clk), .srst(srst), .nvReadAddr(nvReadAddr),
      .nvReadReq(nvReadReq), .nvReadValid(nvReadValid), .nvReadData(nvReadData));
   initial begin
      forever #2 clk = ~clk;
   end
   task end_of_test;
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd
   // Array write, command code, then look for start or violation
   task cmd(input logic [24:0] c);
      @(posedge clk);
      arrayWr <= 1'b1;
      arrayAddr <= c[16:1];
      @(posedge clk);
      arrayWr <= 1'b0;
      regWr <= 1'b1;
      regAddr <= FCP_CMD_OFFSET;
      regWdata <= c[24:17];
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
      #1 chk(cmdStart, c[0]);
      if (c[0]) chk(cmdCode, c[24:17]);
      if (c[0]) chk(cmdAddr[15:8], c[16:9]);
      if (c[0]) chk(cmdAddr[7:0], c[8:1]);
      rd(FCP_STAT_OFFSET, rv);
      chk(rv[FCP_STAT_PV_BIT], !c[0]);
      wr(FCP_STAT_OFFSET, 8'h20);
   endtask : cmd
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      end_of_test;
   end
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (10) @(posedge clk);
      rd(FCP_PROT_OFFSET, rv);
      chk(rv, 8'hFD);
      for (int i = 0; i < 13; i++) begin
         securityState <= ROWS[i][27:20];
         wr(ROWS[i][19:16], ROWS[i][15:8]);
         rd(ROWS[i][19:16], rv);
         chk(rv, ROWS[i][7:0]);
      end
      // Key gate set: array write is a key word, read is invalid
      securityState <= 8'h80;
      wr(FCP_CFG_OFFSET, 8'h20);
      @(posedge clk);
      arrayWr <= 1'b1;
      @(posedge clk);
      arrayWr <= 1'b0;
      #1 chk(keyWordWr, 1'b1);
      @(posedge clk);
      arrayRd <= 1'b1;
      @(posedge clk);
      arrayRd <= 1'b0;
      #1 chk(arrayReadInvalid, 1'b1);
      // Interrupts follow enable and flag
      wr(FCP_CFG_OFFSET, 8'hC0);
      @(posedge clk);
      cmdDoneFlag <= 1'b1;
      bufferEmptySet <= 1'b1;
      @(posedge clk);
      bufferEmptySet <= 1'b0;
      @(posedge clk);
      #1 chk({cmdDoneIrq, bufferEmptyIrq}, 8'h03);
      wr(FCP_STAT_OFFSET, 8'h80);
      @(posedge clk);
      #1 chk(bufferEmptyIrq, 1'b0);
      // Set pulse brings the cleared flag and its request back
      @(posedge clk);
      bufferEmptySet <= 1'b1;
      @(posedge clk);
      bufferEmptySet <= 1'b0;
      @(posedge clk);
      #1 chk(bufferEmptyIrq, 1'b1);
      wr(FCP_CFG_OFFSET, 8'h00);
      @(posedge clk);
      cmdDoneFlag <= 1'b0;
      #1 chk(cmdDoneIrq, 1'b0);
      for (int i = 0; i < 5; i++) cmd(CMDS[i]);
      // Mid-run reset: reset value until the boot byte reloads
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(FCP_PROT_OFFSET, rv);
      chk(rv, FCP_PROT_RESET);
      repeat (10) @(posedge clk);
      rd(FCP_PROT_OFFSET, rv);
      chk(rv, 8'hFD);
      end_of_test;
   end
endmodule : tb_top
bind fcp_flash_protect fcp_flash_protect_checker u_fcp_flash_protect_checker (.clk(clk),
   .srst(srst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
   .cmdDoneFlag(cmdDoneFlag), .arrayWr(arrayWr), .arrayRd(arrayRd),
   .nvReadAddr(nvReadAddr), .nvReadReq(nvReadReq), .cmdStart(cmdStart),
   .keyWordWr(keyWordWr), .arrayReadInvalid(arrayReadInvalid),
   .bufferEmptyIrq(bufferEmptyIrq), .cmdDoneIrq(cmdDoneIrq));
